// ==== dee_ctrl.sv ====
/*
  Data EEPROM erase/program controller: register file on Avalon-MM,
  unlock key sequencer, write-permit guard, cycle timer and the
  command interface to the EEPROM array.
  Assumes the CPU's table write unit and the array run on ref_clk;
  the array starts an operation on eeGo and needs no further handshake.
*/
`timescale 1ns/1ps
module dee_ctrl
  import dee_pkg::*;
#(
  parameter int CYCLE_CYC = DEE_CYCLE_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tblWrStb,
  input wire logic [23:0] tblWrAddr,
  input wire logic [15:0] tblWrData,
  output logic eeGo,
  output dee_cmd_t eeCmd,
  output logic [23:0] eeAddr,
  output logic [15:0] eeData,
  output logic opBusy,
  output logic opDone,
  output logic opCompleteFlag
);

  typedef enum logic [0:0] {
    DEE_ST_IDLE,
    DEE_ST_RUN
  } dee_state_t;

  typedef enum logic [1:0] {
    DEE_KEY_IDLE,
    DEE_KEY_HALF,
    DEE_KEY_ARMED
  } dee_key_t;

  // true when the word index of a byte address matches an offset
  function automatic logic regHit(input logic [4:0] addr,
                                  input logic [4:0] ofs);
    regHit = (addr[4:2] == ofs[4:2]);
  endfunction : regHit

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    mergeLanes[7:0] = be[0] ? wd[7:0] : old[7:0];
    mergeLanes[15:8] = be[1] ? wd[15:8] : old[15:8];
  endfunction : mergeLanes

  // map an operation select to an array command, none if illegal
  function automatic dee_cmd_t opToCmd(input logic [6:0] op);
    case (op)
      DEE_OP_BLOCK_ERASE: opToCmd = DEE_CMD_BLOCK_ERASE;
      DEE_OP_WORD_ERASE: opToCmd = DEE_CMD_WORD_ERASE;
      DEE_OP_WORD_PROG: opToCmd = DEE_CMD_WORD_PROG;
      default: opToCmd = DEE_CMD_NONE;
    endcase
  endfunction : opToCmd

  localparam logic [DEE_CNT_W-1:0] CYC_LAST = DEE_CNT_W'(CYCLE_CYC - 1);

  // state registers
  logic ackQ;
  logic [31:0] rdDataQ;
  logic ctlStartQ;
  logic ctlStartD;
  logic ctlPermitQ;
  logic ctlPermitD;
  logic [6:0] ctlOpQ;
  logic [6:0] ctlOpD;
  logic [15:0] adrLowQ;
  logic [15:0] adrLowD;
  logic [7:0] adrUpQ;
  logic [7:0] adrUpD;
  logic [15:0] latchQ;
  logic [15:0] latchD;
  logic latchFullQ;
  logic latchFullD;
  logic flagQ;
  logic flagD;
  dee_state_t stateQ;
  dee_state_t stateD;
  dee_key_t keyQ;
  dee_key_t keyD;
  logic [DEE_CNT_W-1:0] cntQ;
  logic [DEE_CNT_W-1:0] cntD;

  // bus handshake: every access takes one wait state
  wire busReq = avs_read | avs_write;
  wire rdLoad = avs_read & ~ackQ;
  wire wrAccept = avs_write & ackQ;

  assign avs_waitrequest = busReq & ~(ackQ & ce); // no accept while frozen
  assign avs_readdata = rdDataQ;

  // register address decode
  wire hitCtl = regHit(avs_address, DEE_OFS_CTRL);
  wire hitAdrL = regHit(avs_address, DEE_OFS_ADRL);
  wire hitAdrU = regHit(avs_address, DEE_OFS_ADRU);
  wire hitKey = regHit(avs_address, DEE_OFS_KEY);
  wire hitStat = regHit(avs_address, DEE_OFS_STAT);
  wire hitLatch = regHit(avs_address, DEE_OFS_LATCH);
  wire wrCtl = wrAccept & hitCtl;
  wire wrAdrL = wrAccept & hitAdrL;
  wire wrAdrU = wrAccept & hitAdrU & avs_byteenable[0];
  wire wrKey = wrAccept & hitKey;
  wire wrStat = wrAccept & hitStat;

  // register views for reads
  wire [15:0] ctlView = {ctlStartQ, ctlPermitQ, 7'h00, ctlOpQ};
  wire [15:0] statView = {13'h0000, latchFullQ, ctlStartQ, flagQ};
  wire [31:0] rdMux =
    hitCtl ? {16'h0000, ctlView} :
    hitAdrL ? {16'h0000, adrLowQ} :
    hitAdrU ? {24'h000000, adrUpQ} :
    hitStat ? {16'h0000, statView} :
    hitLatch ? {16'h0000, latchQ} :
    32'h00000000;

  // control write decoded into its fields
  wire [15:0] ctlNew = mergeLanes(ctlView, avs_writedata, avs_byteenable);
  wire startReq = ctlNew[DEE_CTL_START_BIT];
  wire permitNew = ctlNew[DEE_CTL_PERMIT_BIT];
  wire [6:0] opNew = ctlNew[DEE_CTL_OP_MSB:0];
  wire dee_cmd_t cmdNew = opToCmd(opNew);

  // key byte as seen on lane 0
  wire keyFirst = wrKey & avs_byteenable[0] &
                  (avs_writedata[7:0] == DEE_KEY_FIRST);
  wire keySecond = wrKey & avs_byteenable[0] &
                   (avs_writedata[7:0] == DEE_KEY_SECOND);

  // launch: armed keys, permit already set, idle, legal operation
  // permit set before
  wire startOk = wrCtl & startReq & ~ctlStartQ & ctlPermitQ &
                 (keyQ == DEE_KEY_ARMED) & (cmdNew != DEE_CMD_NONE);

  // end of the timed cycle
  wire cycEnd = (stateQ == DEE_ST_RUN) & (cntQ == CYC_LAST);

  // completion flag clear request, write one to bit 0
  wire flagClr = wrStat & avs_byteenable[0] &
                 avs_writedata[DEE_STAT_FLAG_BIT];

  // unlock key sequencer, every accepted write moves it
  // ordered key check
  assign keyD = !wrAccept ? keyQ :
                keyFirst ? DEE_KEY_HALF :
                (keySecond & (keyQ == DEE_KEY_HALF)) ? DEE_KEY_ARMED :
                DEE_KEY_IDLE;

  // control register fields
  always_comb
  begin
    ctlPermitD = ctlPermitQ;
    ctlOpD = ctlOpQ;
    ctlStartD = ctlStartQ;
    if (wrCtl)
      ctlPermitD = permitNew;
    // operation select is frozen while a cycle runs
    if (wrCtl & ~ctlStartQ)
      ctlOpD = opNew;
    if (startOk)
      ctlStartD = 1'b1;
    else if (cycEnd)
      ctlStartD = 1'b0;
  end

  // address registers and the table write latch
  always_comb
  begin
    adrLowD = adrLowQ;
    adrUpD = adrUpQ;
    latchD = latchQ;
    latchFullD = latchFullQ;
    if (tblWrStb)
    begin
      adrLowD = tblWrAddr[15:0];
      adrUpD = tblWrAddr[23:16];
      latchD = tblWrData;
      latchFullD = 1'b1;
    end
    // direct software writes override a same-cycle table write
    if (wrAdrL)
      adrLowD = mergeLanes(adrLowQ, avs_writedata, avs_byteenable);
    if (wrAdrU)
      adrUpD = avs_writedata[7:0];
    // a program launch consumes the latch
    if (startOk & (cmdNew == DEE_CMD_WORD_PROG))
      latchFullD = 1'b0;
  end

  // cycle sequencer and timer
  always_comb
  begin
    stateD = stateQ;
    cntD = cntQ;
    unique case (stateQ)
      DEE_ST_IDLE:
      begin
        cntD = '0;
        if (startOk)
          stateD = DEE_ST_RUN;
      end
      DEE_ST_RUN:
      begin
        if (cycEnd)
        begin
          stateD = DEE_ST_IDLE;
          cntD = '0;
        end
        else
          cntD = cntQ + DEE_CNT_W'(1);
      end
    endcase
  end

  // completion flag, a same-cycle set beats the clear
  // set flag at end
  assign flagD = cycEnd | (flagQ & ~flagClr);

  // bus handshake and read data
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ackQ <= 1'b0;
      rdDataQ <= 32'h00000000;
    end
    else if (ce)
    begin
      ackQ <= busReq & ~ackQ;
      if (rdLoad)
        rdDataQ <= rdMux;
    end
  end

  // register file state
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctlStartQ <= 1'b0;
      ctlPermitQ <= 1'b0;
      ctlOpQ <= DEE_OP_RST;
      adrLowQ <= DEE_ADRL_RST;
      adrUpQ <= DEE_ADRU_RST;
      latchQ <= DEE_LATCH_RST;
      latchFullQ <= 1'b0;
      flagQ <= 1'b0;
      keyQ <= DEE_KEY_IDLE;
    end
    else if (ce)
    begin
      ctlStartQ <= ctlStartD;
      ctlPermitQ <= ctlPermitD;
      ctlOpQ <= ctlOpD;
      adrLowQ <= adrLowD;
      adrUpQ <= adrUpD;
      latchQ <= latchD;
      latchFullQ <= latchFullD;
      flagQ <= flagD;
      keyQ <= keyD;
    end
  end

  // sequencer state and timer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stateQ <= DEE_ST_IDLE;
      cntQ <= '0;
      opDone <= 1'b0;
    end
    else if (ce)
    begin
      stateQ <= stateD;
      cntQ <= cntD;
      opDone <= cycEnd;
    end
  end

  // array command, captured at launch so later register writes
  // cannot disturb a running cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      eeGo <= 1'b0;
      eeCmd <= DEE_CMD_NONE;
      eeAddr <= 24'h000000;
      eeData <= 16'h0000;
    end
    else if (ce)
    begin
      eeGo <= startOk;
      if (startOk)
      begin
        eeCmd <= cmdNew;
        eeAddr <= {adrUpQ, adrLowQ};
        eeData <= latchQ;
      end
    end
  end

  // level outputs straight from the register file
  assign opBusy = ctlStartQ;
  assign opCompleteFlag = flagQ;

endmodule : dee_ctrl

// ==== dee_ctrl_properties.sv ====
/*
  Port checker for dee_ctrl: launch, cycle length, completion flag.
  Assumes one ref_clk domain, bound to every dee_ctrl instance.
*/
`timescale 1ns/1ps
module dee_ctrl_properties
  import dee_pkg::*;
#(
  parameter int CYCLE_CYC = 20
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic eeGo,
  input wire dee_cmd_t eeCmd,
  input wire logic [23:0] eeAddr,
  input wire logic opBusy,
  input wire logic opDone,
  input wire logic opCompleteFlag
);
  logic [19:0] busyCnt_q;
  logic [19:0] busyCnt_d;
  logic wrAcc;
  // busy cycle count and accepted write
  assign busyCnt_d = opBusy ? busyCnt_q + 20'h1 : 20'h0;
  assign wrAcc = avs_write & ~avs_waitrequest;
  // counter runs while busy
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      busyCnt_q <= 20'h0;
    else if (ce)
      busyCnt_q <= busyCnt_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !ce);
  go_rise_a: assert property (eeGo |-> $rose(opBusy))
    else $error("launch without busy rising");
  start_cause_a: assert property ($rose(opBusy) |->
    $past(wrAcc && avs_address[4:2] == 3'h0 && avs_writedata[15]))
    else $error("busy without start write");
  go_once_a: assert property ($past(opBusy) |-> !eeGo)
    else $error("second launch while busy");
  cycle_len_a: assert property ($fell(opBusy) |->
    busyCnt_q == CYCLE_CYC)
    else $error("cycle length wrong");
  done_flag_a: assert property ($fell(opBusy) |->
    opDone && opCompleteFlag)
    else $error("no completion at cycle end");
  done_cause_a: assert property (opDone |-> $fell(opBusy))
    else $error("done without cycle end");
  flag_keep_a: assert property (opCompleteFlag && !(wrAcc &&
    avs_address[4:2] == 3'h4 && avs_writedata[0]) |=> opCompleteFlag)
    else $error("flag cleared by hardware");
  cmd_hold_a: assert property (opBusy && !eeGo |->
    $stable(eeCmd) && $stable(eeAddr))
    else $error("command moved during cycle");
  wait_state_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state wrong");
  cover property (eeGo && eeCmd == DEE_CMD_WORD_PROG);
  cover property ($fell(opBusy));
  cover property (wrAcc && avs_address[4:2] == 3'h3);
endmodule : dee_ctrl_properties

bind dee_ctrl dee_ctrl_properties #(.CYCLE_CYC(CYCLE_CYC)) chk (
  .ref_clk, .rst_n, .ce, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .eeGo, .eeCmd, .eeAddr, .opBusy,
  .opDone, .opCompleteFlag);

// ==== dee_ctrl_tb.sv ====
/*
  Self-checking bench for dee_ctrl over Avalon-MM and table strobe.
  Assumes the checker is bound; short cycle time of 20 clocks.
*/
`timescale 1ns/1ps
module dee_ctrl_tb
  import dee_pkg::*;
;
  localparam int CYC = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tblWrStb = 1'b0;
  logic [23:0] tblWrAddr = 24'h0;
  logic [15:0] tblWrData = 16'h0;
  logic eeGo, opBusy, opDone, opCompleteFlag;
  dee_cmd_t eeCmd;
  logic [23:0] eeAddr;
  logic [15:0] eeData;
  int miscompares = 0;
  int totalChecks = 0;
  int goCnt = 0;
  int cycles = 0;
  int goAt = 0;
  int doneAt = 0;

  dee_ctrl #(.CYCLE_CYC(CYC)) DUT (.ref_clk, .rst_n, .ce, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .tblWrStb, .tblWrAddr, .tblWrData,
    .eeGo, .eeCmd, .eeAddr, .eeData, .opBusy, .opDone, .opCompleteFlag);

  // clock
  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // launch count and hang limit
  always @(posedge ref_clk)
  begin
    cycles++;
    if (eeGo === 1'b1)
    begin
      goCnt <= goCnt + 1;
      goAt <= cycles;
    end
    if (opDone === 1'b1)
      doneAt <= cycles;
    if (cycles == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic t_reset;
    rd(DEE_OFS_CTRL, 32'h0);
    rd(DEE_OFS_STAT, 32'h0);
    rd(DEE_OFS_KEY, 32'h0);
    rd(5'h18, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_refuse;
    logic [7:0] ka [4] = '{8'h55, 8'hAA, 8'h55, 8'h00};
    logic [7:0] kb [4] = '{8'hAA, 8'h55, 8'h55, 8'hAA};
    int g;
    g = goCnt;
    wr(DEE_OFS_CTRL, 32'h0044);
    wr(DEE_OFS_KEY, 32'h55);
    wr(DEE_OFS_KEY, 32'hAA);
    wr(DEE_OFS_CTRL, 32'hC044);
    rd(DEE_OFS_CTRL, 32'h4044);
    // broken key orders, one with a write between the keys
    for (int i = 0; i < 4; i++)
    begin
      wr(DEE_OFS_KEY, {24'h000000, ka[i]});
      if (i == 0)
        wr(DEE_OFS_ADRL, 32'h0);
      wr(DEE_OFS_KEY, {24'h000000, kb[i]});
      wr(DEE_OFS_CTRL, 32'hC044);
    end
    wr(DEE_OFS_CTRL, 32'hC044);
    chk(goCnt, g);
    chk(32'(opBusy), 32'h0);
    $display("refusal test done");
  endtask : t_refuse

  task automatic run_op(input logic [6:0] op, input dee_cmd_t cmd,
    input logic [23:0] ad, input logic [15:0] dt, input logic drop);
    int g;
    int n;
    g = goCnt;
    n = 0;
    wr(DEE_OFS_CTRL, 32'h4000 | op);
    wr(DEE_OFS_KEY, 32'h55);
    wr(DEE_OFS_KEY, 32'hAA);
    wr(DEE_OFS_CTRL, 32'hC000 | op);
    chk(opBusy, 32'h1);
    chk(eeCmd, cmd);
    chk(eeAddr, ad);
    chk(eeData, dt);
    // a second start while running, then maybe drop the permit
    wr(DEE_OFS_KEY, 32'h55);
    wr(DEE_OFS_KEY, 32'hAA);
    wr(DEE_OFS_CTRL, 32'hC000 | op);
    if (drop)
      wr(DEE_OFS_CTRL, 32'h0);
    while (opDone !== 1'b1 && n < 4 * CYC)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 4 * CYC, 32'h1);
    chk(goCnt, g + 1);
    chk(opCompleteFlag, 32'h1);
    rd(DEE_OFS_CTRL, drop ? op : 32'h4000 | op);
    chk(doneAt - goAt, CYC);
    rd(DEE_OFS_STAT, 32'h1);
    wr(DEE_OFS_STAT, 32'h1);
    rd(DEE_OFS_STAT, 32'h0);
    $display("operation %h done", op);
  endtask : run_op

  task automatic t_prog;
    tblWrAddr <= 24'hABCDEF;
    tblWrData <= 16'h5A5A;
    tblWrStb <= 1'b1;
    @(posedge ref_clk);
    tblWrStb <= 1'b0;
    @(posedge ref_clk);
    rd(DEE_OFS_ADRL, 32'hCDEF);
    rd(DEE_OFS_ADRU, 32'hAB);
    rd(DEE_OFS_LATCH, 32'h5A5A);
    rd(DEE_OFS_STAT, 32'h4);
    run_op(DEE_OP_WORD_PROG, DEE_CMD_WORD_PROG, 24'hABCDEF, 16'h5A5A,
      1'b0);
    $display("program test done");
  endtask : t_prog

  // clock enable low while a write waits: nothing may be taken
  task automatic t_freeze;
    fork
      wr(DEE_OFS_ADRU, 32'h3C);
      begin
        @(posedge ref_clk);
        ce <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    rd(DEE_OFS_ADRU, 32'h3C);
    $display("freeze test done");
  endtask : t_freeze

  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_refuse();
    wr(DEE_OFS_ADRU, 32'h01);
    wr(DEE_OFS_ADRL, 32'h0246);
    run_op(DEE_OP_WORD_ERASE, DEE_CMD_WORD_ERASE, 24'h010246, 16'h0,
      1'b0);
    wr(DEE_OFS_ADRU, 32'h7F);
    wr(DEE_OFS_ADRL, 32'hFFE0);
    run_op(DEE_OP_BLOCK_ERASE, DEE_CMD_BLOCK_ERASE, 24'h7FFFE0, 16'h0,
      1'b1);
    t_prog();
    t_freeze();
    stop_test();
  end
endmodule : dee_ctrl_tb

// ==== dee_pkg.sv ====
/*
  Shared constants for the data EEPROM erase/program controller:
  register offsets, field positions, reset values, operation codes
  and cycle timing.
  Assumes a 200 MHz ref_clk and a 32-bit Avalon-MM register bus with
  byte addresses.
*/
package dee_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [4:0] DEE_OFS_CTRL = 5'h00;  // nonvolatile_control_reg
  localparam logic [4:0] DEE_OFS_ADRL = 5'h04;  // target_addr_low_reg
  localparam logic [4:0] DEE_OFS_ADRU = 5'h08;  // target_addr_upper_reg
  localparam logic [4:0] DEE_OFS_KEY = 5'h0C;   // unlock_key_reg
  localparam logic [4:0] DEE_OFS_STAT = 5'h10;  // status and completion flag
  localparam logic [4:0] DEE_OFS_LATCH = 5'h14; // table write latch view

  // control register field positions
  localparam int DEE_CTL_START_BIT = 15;
  localparam int DEE_CTL_PERMIT_BIT = 14;
  localparam int DEE_CTL_OP_MSB = 6;

  // status register field positions
  localparam int DEE_STAT_FLAG_BIT = 0;
  localparam int DEE_STAT_BUSY_BIT = 1;
  localparam int DEE_STAT_LATCH_BIT = 2;

  // operation select encodings in control bits 6:0
  localparam logic [6:0] DEE_OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] DEE_OP_WORD_ERASE = 7'h44;
  localparam logic [6:0] DEE_OP_WORD_PROG = 7'h04;

  // unlock key values, written back to back
  localparam logic [7:0] DEE_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEE_KEY_SECOND = 8'hAA;

  // reset values
  localparam logic [6:0] DEE_OP_RST = 7'h00;
  localparam logic [15:0] DEE_ADRL_RST = 16'h0000;
  localparam logic [7:0] DEE_ADRU_RST = 8'h00;
  localparam logic [15:0] DEE_LATCH_RST = 16'h0000;

  // cycle timing: nominal erase/program time and clock period
  localparam longint DEE_CYCLE_TIME_NS = 2000000;
  localparam longint DEE_CLK_PERIOD_NS = 5;
  localparam int DEE_CYCLE_CYC = int'(DEE_CYCLE_TIME_NS / DEE_CLK_PERIOD_NS);
  localparam int DEE_CNT_W = 20;

  // command code sent to the array
  typedef enum logic [1:0] {
    DEE_CMD_NONE = 2'h0,
    DEE_CMD_BLOCK_ERASE = 2'h1,
    DEE_CMD_WORD_ERASE = 2'h2,
    DEE_CMD_WORD_PROG = 2'h3
  } dee_cmd_t;

endpackage : dee_pkg
